// File: dv/count_source_model.sv
// Model of the external count pin and the capacitive sensing oscillator.
// Assumes the bench calls toggle() right after a rising pclk edge.
`default_nettype none

module count_source_model (
    // Clock
    input  wire logic pclk,
    // Count sources
    output var  logic external_count_input,
    output var  logic cap_sense_oscillator
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////
    // Both sources idle low
    initial begin
        external_count_input = 1'b0;
        cap_sense_oscillator = 1'b0;
    end

    // Flip one source n times; levels last 12 pclk so that the
    // two-flop sync and the Q2/Q4 sampling never miss a level
    task automatic toggle(input logic osc, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (12) @(posedge pclk);
            if (osc) begin
                cap_sense_oscillator <= ~cap_sense_oscillator;
            end else begin
                external_count_input <= ~external_count_input;
            end
        end
        repeat (12) @(posedge pclk);
    endtask

endmodule

`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the 8-bit timer/counter behind APB.
// Assumes the package and the source model are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        ext_in, cap_osc, sleep, wd_clr, wd_tick, wd_out, wdc_out, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, a;
    logic [1:0]  lvl;
    int          fail_count, check_count, s;
    int          wdp = 0;
    int          wdc = 0;

    timer8_with_shared_prescaler i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext_in), .cap_sense_oscillator(cap_osc), .sleep(sleep),
        .watchdog_clear_instruction(wd_clr), .watchdog_tick(wd_tick),
        .watchdog_prescaled(wd_out), .watchdog_counter_clear(wdc_out), .irq(irq));

    count_source_model i_src (.pclk(pclk), .external_count_input(ext_in), .cap_sense_oscillator(cap_osc));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, pulse tally of the watchdog outputs, hang guard
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (wd_out === 1'b1) wdp++;
        if (wdc_out === 1'b1) wdc++;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; leading edge keeps psel low between transfers
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Count gained between two reads n pclk apart
    task automatic delta(input int n, input logic [31:0] exp);
        apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
        a = q;
        repeat (n - 4) @(posedge pclk);
        apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
        check((q - a) & 32'hFF, exp);
    endtask

    task automatic strobe(input logic clr);
        if (clr) wd_clr <= 1'b1;
        else wd_tick <= 1'b1;
        @(posedge pclk);
        wd_clr <= 1'b0;
        wd_tick <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, sleep, wd_clr, wd_tick, paddr, pwdata} = '0;
        {fail_count, check_count, lvl} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, last word unmapped
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(q, 32'h0);
            check({31'h0, err}, {31'h0, i == 6});
        end
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'hFFFFFFFF);
        apb(1'b0, timer8_pkg::ADDR_OPTION, 32'h0);
        check(q, 32'h3F);
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h08);
        delta(400, 32'h64);
        // Sixteen pclk hold four Q4 edges, two of them blocked
        apb(1'b1, timer8_pkg::ADDR_COUNT, 32'hF0);
        repeat (14) @(posedge pclk);
        apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
        check(q, 32'hF2);
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, timer8_pkg::ADDR_OPTION, 32'(n));
            delta(16 << n, 32'h2);
        end
        // Without the second clear the 1:256 prescaler would step the count here
        apb(1'b1, timer8_pkg::ADDR_COUNT, 32'h0);
        repeat (400) @(posedge pclk);
        apb(1'b1, timer8_pkg::ADDR_COUNT, 32'h0);
        repeat (400) @(posedge pclk);
        apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
        check(q, 32'h0);
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h08);
        sleep <= 1'b1;
        delta(200, 32'h0);
        sleep <= 1'b0;
        // Overflow with enable off, then unmask and clear
        apb(1'b1, timer8_pkg::ADDR_INTCTL, 32'h0);
        apb(1'b1, timer8_pkg::ADDR_COUNT, 32'hFF);
        repeat (40) @(posedge pclk);
        apb(1'b0, timer8_pkg::ADDR_INTCTL, 32'h0);
        check(q, 32'h04);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, timer8_pkg::ADDR_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, timer8_pkg::ADDR_INTCTL, 32'h24);
        repeat (200) @(posedge pclk);
        apb(1'b0, timer8_pkg::ADDR_STATUS, 32'h0);
        check(q, 32'h1);
        apb(1'b1, timer8_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, timer8_pkg::ADDR_STATUS, 32'h0);
        check(q, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, timer8_pkg::ADDR_MASK, 32'h0);
        // Counter mode: source and polarity mixed; the idle source must not count
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, timer8_pkg::ADDR_CAPSENSE, 32'(c & 1));
            apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h28 | 32'((c ^ (c >> 1)) & 1) << 4);
            repeat (20) @(posedge pclk);
            apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
            a = q;
            i_src.toggle(1'(c & 1), 9);
            i_src.toggle(1'(~c & 1), 4);
            apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
            check((q - a) & 32'hFF, (lvl[c & 1] == 1'((c ^ (c >> 1)) & 1)) ? 32'h5 : 32'h4);
            lvl[c & 1] = ~lvl[c & 1];
        end
        // Pin edges through the 1:2 prescaler
        apb(1'b1, timer8_pkg::ADDR_CAPSENSE, 32'h0);
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h20);
        repeat (20) @(posedge pclk);
        apb(1'b1, timer8_pkg::ADDR_COUNT, 32'h0);
        i_src.toggle(1'b0, 8);
        apb(1'b0, timer8_pkg::ADDR_COUNT, 32'h0);
        check(q, 32'h2);
        // Prescaler on the watchdog at 1:4
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h09);
        s = wdc;
        strobe(1'b1);
        repeat (3) @(posedge pclk);
        check(32'(wdc - s), 32'h1);
        s = wdp;
        strobe(1'b0);
        strobe(1'b1);
        strobe(1'b0);
        repeat (3) @(posedge pclk);
        check(32'(wdp - s), 32'h0);
        strobe(1'b0);
        repeat (3) @(posedge pclk);
        check(32'(wdp - s), 32'h1);
        apb(1'b1, timer8_pkg::ADDR_OPTION, 32'h01);
        s = wdp;
        repeat (8) strobe(1'b0);
        check(32'(wdp - s), 32'h0);
        s = wdc;
        strobe(1'b1);
        repeat (3) @(posedge pclk);
        check(32'(wdc - s), 32'h0);
        report_and_stop();
    end

endmodule

`default_nettype wire

// File: hdl/timer8_pkg.sv
// Constants, offsets and carriers of the 8-bit timer/counter.
// Assumes one 20 MHz pclk and an APB master on the register side.
// What this block does
// - With the source select clear and no prescaler, the count steps once per instruction cycle.
// - A write to the count blocks counting for the next two instruction cycles.
// - In counter mode without the prescaler the count steps on each chosen edge of the pin or the oscillator.
// - Source select 1 picks counter mode; external select 0 picks the pin, 1 the oscillator.
// - The polarity bit picks rising or falling edges for both external sources.
// - One prescaler serves the counter or the watchdog; assign bit 0 gives it to the counter.
// - On the counter the prescaler offers eight ratios from 1:2 to 1:256 by a 3-bit field.
// - A 1:1 rate is had only by giving the prescaler to the watchdog.
// - The prescaler is hidden, and a count write clears it while it serves the counter.
// - A watchdog clear resets the prescaler and watchdog counter while it serves the watchdog.
// - A wrap from FFh to 00h sets the overflow flag whatever the enable.
// - Only software clears the overflow flag.
// - An interrupt is raised only while both flag and enable are set.
// - In sleep the count holds still.
// - The counting edge is sampled at phases two and four of the instruction cycle.
`default_nettype none

package timer8_pkg;

    // Byte addresses of the registers
    localparam logic [7:0] ADDR_COUNT    = 8'h00;
    localparam logic [7:0] ADDR_OPTION   = 8'h04;
    localparam logic [7:0] ADDR_CAPSENSE = 8'h08;
    localparam logic [7:0] ADDR_INTCTL   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_MASK     = 8'h14;

    // Values after reset
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [5:0] OPTION_RESET = 6'h00;

    // Field positions
    localparam int INTCTL_IE_BIT = 5;
    localparam int INTCTL_IF_BIT = 2;
    localparam int STATUS_OV_BIT = 0;
    localparam int XSEL_BIT      = 0;

    // Instruction cycle phases and cycle counts
    localparam logic [1:0] PHASE_Q2        = 2'h1;
    localparam logic [1:0] PHASE_Q4        = 2'h3;
    localparam logic [1:0] INHIBIT_CYCLES  = 2'h2;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;

    // Option register, bit 5 down to bit 0
    typedef struct packed {
        logic       clock_source_select;
        logic       edge_polarity_select;
        logic       prescaler_assign;
        logic [2:0] prescale_ratio;
    } option_s;

endpackage

`default_nettype wire

// File: hdl/timer8_with_shared_prescaler.sv
// Timer/counter with prescaler shared with the watchdog, APB slave.
// Assumes core strobes (sleep, watchdog clear, watchdog tick) on pclk;
// external count pins are asynchronous and synchronised here.
`default_nettype none

module timer8_with_shared_prescaler #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // External count sources
    input  wire logic              external_count_input,
    input  wire logic              cap_sense_oscillator,
    // Core side
    input  wire logic              sleep,
    input  wire logic              watchdog_clear_instruction,
    input  wire logic              watchdog_tick,
    output var  logic              watchdog_prescaled,
    output var  logic              watchdog_counter_clear,
    // Interrupt
    output var  logic              irq
);

    ////////////////////////////////////////////////////////////////////
    // State

    logic [1:0]          phase;
    logic [7:0]          timer_count;
    timer8_pkg::option_s option;
    logic                external_source_select;
    logic                overflow_irq_enable;
    logic                overflow_flag;
    logic [7:0]          prescaler;
    logic [1:0]          inhibit;
    logic                pin_meta;
    logic                pin_sync;
    logic                cap_meta;
    logic                cap_sync;
    logic                src_prev;
    logic                q2_sample;
    logic                q4_last;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    // Write lands at the edge where pready is seen high
    wire       access    = psel && penable;
    wire       wr        = access && pready && pwrite;
    wire [7:0] addr      = paddr[7:0];
    wire       sel_count = addr == timer8_pkg::ADDR_COUNT;
    wire       sel_opt   = addr == timer8_pkg::ADDR_OPTION;
    wire       sel_cap   = addr == timer8_pkg::ADDR_CAPSENSE;
    wire       sel_ictl  = addr == timer8_pkg::ADDR_INTCTL;
    wire       sel_stat  = addr == timer8_pkg::ADDR_STATUS;
    wire       sel_mask  = addr == timer8_pkg::ADDR_MASK;
    wire       mapped    = sel_count || sel_opt || sel_cap || sel_ictl || sel_stat || sel_mask;
    wire       wr_count  = wr && sel_count;
    wire       wr_opt    = wr && sel_opt;
    wire       wr_cap    = wr && sel_cap;
    wire       wr_ictl   = wr && sel_ictl;
    wire       wr_stat   = wr && sel_stat;
    wire       wr_mask   = wr && sel_mask;

    // Read mux; unused bits read zero and the prescaler is never visible
    wire [7:0] ictl_rd = 8'(overflow_irq_enable) << timer8_pkg::INTCTL_IE_BIT
                       | 8'(overflow_flag) << timer8_pkg::INTCTL_IF_BIT;
    wire [7:0] rd_byte = sel_count ? timer_count :
                         sel_opt   ? {2'h0, option} :
                         sel_cap   ? 8'(external_source_select) :
                         sel_ictl  ? ictl_rd :
                         sel_stat  ? 8'(overflow_flag) :
                         sel_mask  ? 8'(overflow_irq_enable) : 8'h00;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access && !pready;
            prdata  <= {24'h00_0000, rd_byte};
            pslverr <= access && !pready && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction cycle phases, Q1 to Q4 as 0 to 3

    wire at_q2 = phase == timer8_pkg::PHASE_Q2;
    wire at_q4 = phase == timer8_pkg::PHASE_Q4;

    // Free-running phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) phase <= 2'h0;
        else          phase <= phase + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // External source synchronisers

    // Two flops per pin; only the second stage is used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            cap_meta <= 1'b0;
            cap_sync <= 1'b0;
        end else begin
            pin_meta <= external_count_input;
            pin_sync <= pin_meta;
            cap_meta <= cap_sense_oscillator;
            cap_sync <= cap_meta;
        end
    end

    // Source pick and polarity; high polarity makes falling edges count
    wire src_raw   = external_source_select ? cap_sync : pin_sync;
    wire src_level = src_raw ^ option.edge_polarity_select;
    wire src_rise  = src_level && !src_prev;

    ////////////////////////////////////////////////////////////////////
    // Shared prescaler

    wire       to_wdt     = option.prescaler_assign;
    wire       cnt_mode   = option.clock_source_select;
    wire [2:0] ratio      = option.prescale_ratio;
    // Counter-side ticks freeze with the timer in sleep
    wire       tmr_tick   = !sleep && (cnt_mode ? src_rise : at_q4);
    wire       pre_tick   = to_wdt ? watchdog_tick : tmr_tick;
    wire       pre_clr    = (wr_count && !to_wdt)
                         || (watchdog_clear_instruction && to_wdt);
    wire [7:0] pre_inc    = prescaler + 8'h01;
    wire [7:0] next_pre   = pre_clr ? 8'h00 : (pre_tick ? pre_inc : prescaler);
    // Bit n toggles every 2^n ticks, so its rises come every 2^(n+1)
    wire       pre_bit    = prescaler[ratio];
    wire       wdt_pulse  = to_wdt && !pre_clr && pre_tick && !pre_bit && pre_inc[ratio];

    // Prescaler count and watchdog-facing strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler              <= 8'h00;
            src_prev               <= 1'b0;
            watchdog_prescaled     <= 1'b0;
            watchdog_counter_clear <= 1'b0;
        end else begin
            prescaler              <= next_pre;
            src_prev               <= src_level;
            watchdog_prescaled     <= wdt_pulse;
            watchdog_counter_clear <= watchdog_clear_instruction && to_wdt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase sampling of the divided level

    // Without the prescaler the synced source itself is sampled: 1:1
    wire div_level = to_wdt ? src_level : pre_bit;
    // A rise seen at Q2 or Q4 since the last Q4 is one count
    wire q4_rise   = !q4_last && (q2_sample || div_level);

    // Samples at Q2 and Q4; a second edge within one cycle is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q2_sample <= 1'b0;
            q4_last   <= 1'b0;
        end else begin
            if (at_q2) q2_sample <= div_level;
            if (at_q4) q4_last   <= div_level;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timer count

    // Timer mode without prescaler steps every instruction cycle
    wire       direct_inc = !cnt_mode && to_wdt;
    wire       inc_req    = at_q4 && (direct_inc || q4_rise);
    wire       count_inc  = inc_req && !sleep && !wr_count
                         && inhibit == 2'h0;
    wire       wrap       = count_inc && timer_count == timer8_pkg::COUNT_MAX;
    wire [7:0] next_count = wr_count ? pwdata[7:0] :
                            count_inc ? timer_count + 8'h01 : timer_count;

    // Write arms the two-cycle inhibit, which drains on Q4 edges
    wire [1:0] next_inh = wr_count ? timer8_pkg::INHIBIT_CYCLES :
                          (at_q4 && inhibit != 2'h0) ? inhibit - 2'h1 : inhibit;

    // Count and inhibit registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= timer8_pkg::COUNT_RESET;
            inhibit     <= 2'h0;
        end else begin
            timer_count <= next_count;
            inhibit     <= next_inh;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Option, source select and enable; status-mask view shares the enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option                 <= timer8_pkg::OPTION_RESET;
            external_source_select <= 1'b0;
            overflow_irq_enable    <= 1'b0;
        end else begin
            if (wr_opt) option <= pwdata[5:0];
            if (wr_cap) external_source_select <= pwdata[timer8_pkg::XSEL_BIT];
            if (wr_ictl) overflow_irq_enable <= pwdata[timer8_pkg::INTCTL_IE_BIT];
            else if (wr_mask) overflow_irq_enable <= pwdata[timer8_pkg::STATUS_OV_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Overflow flag and interrupt

    // Clear by a zero in the control view or a one in the status view
    wire flag_clr  = (wr_ictl && !pwdata[timer8_pkg::INTCTL_IF_BIT])
                  || (wr_stat && pwdata[timer8_pkg::STATUS_OV_BIT]);
    // Set wins over a clear in the same cycle so no wrap is lost
    wire next_flag = wrap || (overflow_flag && !flag_clr);

    // Flag and gated interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
            irq           <= 1'b0;
        end else begin
            overflow_flag <= next_flag;
            irq           <= overflow_flag && overflow_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    phase_walk_a: assert property (@(posedge pclk) disable iff (!presetn)
        at_q4 |=> phase == 2'h0 ##3 at_q4)
        else $error("phase sequence broken");

    timer_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (at_q4 && direct_inc && !sleep && inhibit == 2'h0 && !wr_count)
        |=> timer_count == $past(timer_count) + 8'h01)
        else $error("timer mode missed a step");

    write_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_count ##1 (!wr_count && !(at_q4 && inhibit == 2'h1)) [*1]
        |=> timer_count == $past(timer_count))
        else $error("count moved during inhibit");

    inhibit_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> inhibit == 2'h2)
        else $error("write did not arm inhibit");

    presc_wrclr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_count && !to_wdt) |=> prescaler == 8'h00)
        else $error("count write left prescaler");

    presc_wdtclr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (watchdog_clear_instruction && to_wdt) |=> prescaler == 8'h00 && watchdog_counter_clear)
        else $error("watchdog clear missed");

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (count_inc && timer_count == 8'hFF) |=> overflow_flag && timer_count == 8'h00)
        else $error("wrap did not set flag");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow_flag && !flag_clr) |=> overflow_flag)
        else $error("flag cleared without software");

    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(overflow_flag && overflow_irq_enable))
        else $error("interrupt not gated by enable");

    sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep && !wr_count) |=> $stable(timer_count))
        else $error("count moved in sleep");

    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready stood two cycles");

    pready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("pready late");

    slverr_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");

    count_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> timer_count == $past(pwdata[7:0]))
        else $error("count write lost");

    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_count |=> (timer_count == $past(timer_count)) || (timer_count == $past(timer_count) + 8'h01))
        else $error("count jumped");

    q4_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!at_q4 && !wr_count) |=> $stable(timer_count))
        else $error("count moved off Q4");

    inhibit_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        (at_q4 && inhibit != 2'h0 && !wr_count) |=> inhibit == $past(inhibit) - 2'h1)
        else $error("inhibit did not drain");

    inhibit_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        (inhibit != 2'h0 && !wr_count) |=> $stable(timer_count))
        else $error("count moved while inhibited");

    presc_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep && !to_wdt && !wr_count) |=> $stable(prescaler))
        else $error("prescaler moved in sleep");

    presc_wdt_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (to_wdt && !watchdog_tick && !watchdog_clear_instruction) |=> $stable(prescaler))
        else $error("counter event moved watchdog prescaler");

    irq_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        !overflow_irq_enable |=> !irq)
        else $error("interrupt while disabled");

    irq_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        !overflow_flag |=> !irq)
        else $error("interrupt without flag");

    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clr && !wrap) |=> !overflow_flag)
        else $error("software clear ignored");

    flag_source_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!overflow_flag && !wrap) |=> !overflow_flag)
        else $error("flag set without wrap");

    wdt_pulse_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !to_wdt |=> !watchdog_prescaled)
        else $error("watchdog tick while prescaler on counter");

    wdt_clear_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !to_wdt |=> !watchdog_counter_clear)
        else $error("watchdog clear strobe while prescaler on counter");

    pin_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_sync == $past(external_count_input, 2))
        else $error("pin sync depth wrong");

    cap_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        cap_sync == $past(cap_sense_oscillator, 2))
        else $error("oscillator sync depth wrong");

endmodule

`default_nettype wire
